// ==== hw/pes_pkg.sv ====
// Shared constants and carrier types for the port error and status bank
package pes_pkg;

    // ==========================================================
    // Address map
    localparam logic [11:0] PES_BASE_OFS = 12'h058;
    localparam logic [11:0] PES_PORT_STRIDE = 12'h020;
    localparam logic [11:0] PES_IRQ_STAT_OFS = 12'h300;
    localparam logic [11:0] PES_IRQ_MASK_OFS = 12'h304;
    localparam int PES_MAX_PORTS = 16;

    // ==========================================================
    // Field positions, given in bit-0-is-MSB numbering
    localparam int PES_DOC_OUT_RETRY_SEEN = 11;
    localparam int PES_DOC_OUT_RETRIED = 12;
    localparam int PES_DOC_OUT_RETRY_HALT = 13;
    localparam int PES_DOC_OUT_ERR_SEEN = 14;
    localparam int PES_DOC_OUT_ERR_HALT = 15;
    localparam int PES_DOC_IN_RETRY_HALT = 21;
    localparam int PES_DOC_IN_ERR_SEEN = 22;
    localparam int PES_DOC_IN_ERR_HALT = 23;
    localparam int PES_DOC_PW_PENDING = 27;
    localparam int PES_DOC_PRESENT = 28;
    localparam int PES_DOC_PORT_ERR = 29;
    localparam int PES_DOC_PORT_OK = 30;
    localparam int PES_DOC_UNINIT = 31;

    // ==========================================================
    // Reset values
    localparam logic PES_RST_UNINIT = 1'h1;
    localparam logic PES_RST_FLAG = 1'h0;
    localparam logic [31:0] PES_RST_WORD = 32'h0000_0000;

    // Bit 0 of the register is the most significant bit of the word
    function automatic int pes_lsb(input int doc_bit);
        return 31 - doc_bit;
    endfunction : pes_lsb

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic out_retry_halted;
        logic out_err_halted;
        logic in_retry_halted;
        logic in_err_halted;
        logic pkt_accepted;
        logic pkt_not_accepted;
        logic pw_needed;
        logic unrecov_err;
        logic clk_present;
        logic initialized;
    } pes_port_in_t;

    typedef struct packed {
        logic [11:0] adr;
        logic [31:0] dat;
        logic [3:0] sel;
        logic we;
        logic cyc;
        logic stb;
    } pes_wb_req_t;

endpackage : pes_pkg

// ==== hw/pes_top.sv ====
// Per-port error and status register bank behind a classic Wishbone slave
`timescale 1ns/1ps

module pes_top #(
    parameter int NUM_PORTS = 16
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Wishbone slave
    input wire pes_pkg::pes_wb_req_t wb_req,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Link protocol machine state, one entry per port
    input wire pes_pkg::pes_port_in_t [NUM_PORTS-1:0] port_in,
    // Register image per port for device use
    output logic [NUM_PORTS-1:0][31:0] port_stat_o,
    // Interrupt
    output logic irq_o
);

    // ==========================================================
    // Parameter check
    generate
        if (NUM_PORTS < 1 || NUM_PORTS > pes_pkg::PES_MAX_PORTS) begin : g_bad
            $error("NUM_PORTS must lie between 1 and 16");
        end
    endgenerate

    localparam int L_ORS = pes_pkg::pes_lsb(pes_pkg::PES_DOC_OUT_RETRY_SEEN);
    localparam int L_ORT = pes_pkg::pes_lsb(pes_pkg::PES_DOC_OUT_RETRIED);
    localparam int L_ORH = pes_pkg::pes_lsb(pes_pkg::PES_DOC_OUT_RETRY_HALT);
    localparam int L_OES = pes_pkg::pes_lsb(pes_pkg::PES_DOC_OUT_ERR_SEEN);
    localparam int L_OEH = pes_pkg::pes_lsb(pes_pkg::PES_DOC_OUT_ERR_HALT);
    localparam int L_IRH = pes_pkg::pes_lsb(pes_pkg::PES_DOC_IN_RETRY_HALT);
    localparam int L_IES = pes_pkg::pes_lsb(pes_pkg::PES_DOC_IN_ERR_SEEN);
    localparam int L_IEH = pes_pkg::pes_lsb(pes_pkg::PES_DOC_IN_ERR_HALT);
    localparam int L_PWP = pes_pkg::pes_lsb(pes_pkg::PES_DOC_PW_PENDING);
    localparam int L_PRS = pes_pkg::pes_lsb(pes_pkg::PES_DOC_PRESENT);
    localparam int L_PER = pes_pkg::pes_lsb(pes_pkg::PES_DOC_PORT_ERR);
    localparam int L_POK = pes_pkg::pes_lsb(pes_pkg::PES_DOC_PORT_OK);
    localparam int L_UNI = pes_pkg::pes_lsb(pes_pkg::PES_DOC_UNINIT);

    // ==========================================================
    // Bus handshake: ack one cycle after the request, dropped next cycle
    logic req_w;
    logic wr_fire_w;
    logic [31:0] byte_mask_w;
    logic [31:0] clr_w;
    logic wb_ack_q;
    logic [31:0] wb_dat_q;
    logic [31:0] rd_mux_w;

    assign req_w = wb_req.cyc & wb_req.stb;
    // Writes act at the edge where the master samples ack
    assign wr_fire_w = req_w & wb_req.we & wb_ack_q;

    always_comb begin
        for (int b = 0; b < 4; b++) begin
            byte_mask_w[8*b +: 8] = {8{wb_req.sel[b]}};
        end
    end

    // Only ones in enabled byte lanes clear a flag
    assign clr_w = wb_req.dat & byte_mask_w;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wb_ack_q <= 1'h0;
        end else begin
            wb_ack_q <= req_w & ~wb_ack_q;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wb_dat_q <= pes_pkg::PES_RST_WORD;
        end else if (req_w & ~wb_ack_q & ~wb_req.we) begin
            wb_dat_q <= rd_mux_w;
        end
    end

    assign wb_dat_o = wb_dat_q;
    assign wb_ack_o = wb_ack_q;

    // ==========================================================
    // Per-port register
    logic [NUM_PORTS-1:0][31:0] stat_w;
    logic [NUM_PORTS-1:0] hit_w;
    logic [NUM_PORTS-1:0] event_w;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
            localparam logic [11:0] OFS = pes_pkg::PES_BASE_OFS
                + 12'(gi) * pes_pkg::PES_PORT_STRIDE;
            pes_pkg::pes_port_in_t pi;
            logic [31:0] clr;
            logic ors_q, ort_q, orh_q, oes_q, oeh_q;
            logic irh_q, ies_q, ieh_q, pwp_q, prs_q, per_q, pok_q, uni_q;
            logic ack_rx;

            assign pi = port_in[gi];
            assign hit_w[gi] = wb_req.adr[11:2] == OFS[11:2];
            assign clr = (wr_fire_w & hit_w[gi]) ? clr_w : 32'h0000_0000;
            assign ack_rx = pi.pkt_accepted | pi.pkt_not_accepted;

            // Live state flags, registered once
            always_ff @(posedge sys_clk or negedge arst_n) begin
                if (!arst_n) begin
                    orh_q <= pes_pkg::PES_RST_FLAG;
                    oeh_q <= pes_pkg::PES_RST_FLAG;
                    irh_q <= pes_pkg::PES_RST_FLAG;
                    ieh_q <= pes_pkg::PES_RST_FLAG;
                    prs_q <= pes_pkg::PES_RST_FLAG;
                    pok_q <= pes_pkg::PES_RST_FLAG;
                    uni_q <= pes_pkg::PES_RST_UNINIT;
                end else begin
                    orh_q <= pi.out_retry_halted;
                    oeh_q <= pi.out_err_halted;
                    irh_q <= pi.in_retry_halted;
                    ieh_q <= pi.in_err_halted;
                    prs_q <= pi.clk_present;
                    pok_q <= pi.initialized;
                    uni_q <= ~pi.initialized;
                end
            end

            // Retried: set on entering retry-halted, cleared by an ack
            always_ff @(posedge sys_clk or negedge arst_n) begin
                if (!arst_n) begin
                    ort_q <= pes_pkg::PES_RST_FLAG;
                end else begin
                    ort_q <= (pi.out_retry_halted & ~orh_q)
                        | (ort_q & ~ack_rx);
                end
            end

            // Sticky flags, set wins over a write-one clear
            always_ff @(posedge sys_clk or negedge arst_n) begin
                if (!arst_n) begin
                    ors_q <= pes_pkg::PES_RST_FLAG;
                    oes_q <= pes_pkg::PES_RST_FLAG;
                    ies_q <= pes_pkg::PES_RST_FLAG;
                    pwp_q <= pes_pkg::PES_RST_FLAG;
                    per_q <= pes_pkg::PES_RST_FLAG;
                end else begin
                    ors_q <= pi.out_retry_halted | (ors_q & ~clr[L_ORS]);
                    oes_q <= pi.out_err_halted | (oes_q & ~clr[L_OES]);
                    ies_q <= pi.in_err_halted | (ies_q & ~clr[L_IES]);
                    pwp_q <= pi.pw_needed | (pwp_q & ~clr[L_PWP]);
                    per_q <= pi.unrecov_err | (per_q & ~clr[L_PER]);
                end
            end

            // Any sticky flag newly rising raises the port's event
            assign event_w[gi] = (pi.out_retry_halted & ~ors_q)
                | (pi.out_err_halted & ~oes_q)
                | (pi.in_err_halted & ~ies_q)
                | (pi.pw_needed & ~pwp_q)
                | (pi.unrecov_err & ~per_q);

            // Word assembly, reserved bits tied to zero
            always_comb begin
                stat_w[gi] = 32'h0000_0000;
                stat_w[gi][L_ORS] = ors_q;
                stat_w[gi][L_ORT] = ort_q;
                stat_w[gi][L_ORH] = orh_q;
                stat_w[gi][L_OES] = oes_q;
                stat_w[gi][L_OEH] = oeh_q;
                stat_w[gi][L_IRH] = irh_q;
                stat_w[gi][L_IES] = ies_q;
                stat_w[gi][L_IEH] = ieh_q;
                stat_w[gi][L_PWP] = pwp_q;
                stat_w[gi][L_PRS] = prs_q;
                stat_w[gi][L_PER] = per_q;
                stat_w[gi][L_POK] = pok_q;
                stat_w[gi][L_UNI] = uni_q;
            end
        end
    endgenerate

    // ==========================================================
    // Image output
    logic [NUM_PORTS-1:0][31:0] port_stat_q;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                port_stat_q[p] <= {pes_pkg::PES_RST_WORD[31:1],
                    pes_pkg::PES_RST_UNINIT};
            end
        end else begin
            port_stat_q <= stat_w;
        end
    end

    assign port_stat_o = port_stat_q;

    // ==========================================================
    // Interrupt status and mask, one bit per port
    logic [NUM_PORTS-1:0] irq_stat_q;
    logic [NUM_PORTS-1:0] irq_mask_q;
    logic irq_q;
    logic hit_stat_w;
    logic hit_mask_w;

    assign hit_stat_w = wb_req.adr[11:2] == pes_pkg::PES_IRQ_STAT_OFS[11:2];
    assign hit_mask_w = wb_req.adr[11:2] == pes_pkg::PES_IRQ_MASK_OFS[11:2];

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_stat_q <= '0;
        end else if (wr_fire_w & hit_stat_w) begin
            irq_stat_q <= event_w | (irq_stat_q & ~clr_w[NUM_PORTS-1:0]);
        end else begin
            irq_stat_q <= event_w | irq_stat_q;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_mask_q <= '0;
        end else if (wr_fire_w & hit_mask_w) begin
            irq_mask_q <= (wb_req.dat[NUM_PORTS-1:0]
                & byte_mask_w[NUM_PORTS-1:0])
                | (irq_mask_q & ~byte_mask_w[NUM_PORTS-1:0]);
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_q <= 1'h0;
        end else begin
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end

    assign irq_o = irq_q;

    // ==========================================================
    // Read multiplexer; unmapped words read zero
    always_comb begin
        rd_mux_w = 32'h0000_0000;
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (hit_w[p]) begin
                rd_mux_w = stat_w[p];
            end
        end
        if (hit_stat_w) begin
            rd_mux_w[NUM_PORTS-1:0] = irq_stat_q;
        end
        if (hit_mask_w) begin
            rd_mux_w[NUM_PORTS-1:0] = irq_mask_q;
        end
    end

endmodule : pes_top

// ==== sim/pes_link_model.sv ====
// Link protocol machine model driving the port state inputs
`timescale 1ns/1ps
module pes_link_model #(
    parameter int NUM_PORTS = 16
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Requested state of port 0
    input wire logic [9:0] new_state,
    input wire logic load,
    // State seen by the bank
    output pes_pkg::pes_port_in_t [NUM_PORTS-1:0] port_in
);
    // Received symbols and error events last one cycle; states hold
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            port_in <= '0;
        end else if (load) begin
            port_in[0] <= new_state;
        end else begin
            port_in[0] <= port_in[0] & 10'h3C3;
        end
    end
endmodule : pes_link_model

// ==== sim/pes_top_asserts.sv ====
// Concurrent checks on the port error and status bank ports
`timescale 1ns/1ps
module pes_top_asserts #(
    parameter int NUM_PORTS = 16
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Bus side
    input wire pes_pkg::pes_wb_req_t wb_req,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Port side
    input wire pes_pkg::pes_port_in_t [NUM_PORTS-1:0] port_in,
    input wire logic [NUM_PORTS-1:0][31:0] port_stat_o,
    input wire logic irq_o
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // ==========================================================
    // Bus ack and read checks; port 0 image, two cycles behind its inputs
    a_ack_one_pulse: assert property (
        wb_req.cyc && wb_req.stb && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not one pulse");
    a_err_halt_live: assert property (
        port_stat_o[0][16] == $past(port_in[0].out_err_halted, 2))
        else $error("bit 15 wrong");
    a_in_err_live: assert property (
        port_stat_o[0][8] == $past(port_in[0].in_err_halted, 2))
        else $error("bit 23 wrong");
    a_uninit_live: assert property (
        port_stat_o[0][0] == !$past(port_in[0].initialized, 2))
        else $error("bit 31 wrong");
    a_ok_excl: assert property (
        port_stat_o[0][1] != port_stat_o[0][0])
        else $error("bits 30 and 31 not exclusive");
    a_retry_seen: assert property (
        port_stat_o[0][18] |-> port_stat_o[0][20])
        else $error("bit 11 not set with 13");
    a_err_seen: assert property (
        port_stat_o[0][16] |-> port_stat_o[0][17])
        else $error("bit 14 not set with 15");
    a_in_seen: assert property (
        port_stat_o[0][8] |-> port_stat_o[0][9])
        else $error("bit 22 not set with 23");
    a_retried_clear: assert property (
        (port_in[0].pkt_accepted || port_in[0].pkt_not_accepted)
        && !port_in[0].out_retry_halted |-> ##2 !port_stat_o[0][19])
        else $error("bit 12 stuck");
    a_reserved_zero: assert property (
        (port_stat_o[0] & 32'hFFE0_F8E0) == 32'h0000_0000)
        else $error("reserved bit set");
    a_retry_halt_live: assert property (
        port_stat_o[0][18] == $past(port_in[0].out_retry_halted, 2))
        else $error("bit 13 wrong");
    a_in_retry_live: assert property (
        port_stat_o[0][10] == $past(port_in[0].in_retry_halted, 2))
        else $error("bit 21 wrong");
    a_present_live: assert property (
        port_stat_o[0][3] == $past(port_in[0].clk_present, 2))
        else $error("bit 28 wrong");
    a_pw_pending: assert property (
        port_in[0].pw_needed |-> ##2 port_stat_o[0][4])
        else $error("bit 27 not set");
    a_port_err: assert property (
        port_in[0].unrecov_err |-> ##2 port_stat_o[0][2])
        else $error("bit 29 not set");
    a_retried_set: assert property (
        $rose(port_in[0].out_retry_halted) |-> ##2 port_stat_o[0][19])
        else $error("bit 12 not set with 13");
    a_read_reserved: assert property (
        wb_ack_o && !wb_req.we && wb_req.adr == 12'h058
        |-> (wb_dat_o & 32'hFFE0_F8E0) == 32'h0000_0000)
        else $error("reserved bit read as one");
endmodule : pes_top_asserts

bind pes_top pes_top_asserts #(.NUM_PORTS(NUM_PORTS)) i_pes_top_asserts (
    .sys_clk(sys_clk), .arst_n(arst_n), .wb_req(wb_req),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .port_in(port_in),
    .port_stat_o(port_stat_o), .irq_o(irq_o));

// ==== sim/tb_top.sv ====
// Self-checking bench for the port error and status bank
`timescale 1ns/1ps
module tb_top;
    logic sys_clk;
    logic arst_n;
    pes_pkg::pes_wb_req_t wb_req;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    pes_pkg::pes_port_in_t [15:0] port_in;
    logic [15:0][31:0] port_stat_o;
    logic irq_o;
    logic [9:0] new_state;
    logic load;
    int failures;
    int num_checks;

    pes_top #(.NUM_PORTS(16)) i_pes_top (.sys_clk(sys_clk), .arst_n(arst_n),
        .wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .port_in(port_in), .port_stat_o(port_stat_o), .irq_o(irq_o));
    pes_link_model #(.NUM_PORTS(16)) i_pes_link_model (.sys_clk(sys_clk),
        .arst_n(arst_n), .new_state(new_state), .load(load),
        .port_in(port_in));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // ==========================================================
    // Access tasks
    task check(input string name, input logic [31:0] seen,
               input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task wb(input logic [11:0] adr, input logic we, input logic [31:0] dat,
            input logic [3:0] sel, output logic [31:0] rdat);
        // Request stands until ack is seen; only the watchdog ends a hang
        @(posedge sys_clk);
        wb_req <= '{adr: adr, dat: dat, sel: sel, we: we, cyc: 1'b1,
                    stb: 1'b1};
        do begin
            @(posedge sys_clk);
        end while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        wb_req <= '0;
    endtask : wb

    task rd(input logic [11:0] adr, input logic [31:0] exp, input string nm);
        logic [31:0] v;
        wb(adr, 1'b0, 32'h0000_0000, 4'hF, v);
        check(nm, v, exp);
    endtask : rd

    task wr(input logic [11:0] adr, input logic [31:0] dat,
            input logic [3:0] sel);
        logic [31:0] v;
        wb(adr, 1'b1, dat, sel, v);
    endtask : wr

    task link(input logic [9:0] st);
        @(posedge sys_clk);
        load <= 1'b1;
        new_state <= st;
        @(posedge sys_clk);
        load <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask : link

    task give_verdict;
        if (failures == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict

    // ==========================================================
    // Tests
    initial begin
        arst_n = 1'b0;
        wb_req = '0;
        new_state = '0;
        load = 1'b0;
        failures = 0;
        num_checks = 0;
        repeat (12) @(posedge sys_clk);
        arst_n <= 1'b1;
        rd(12'h058, 32'h0000_0001, "port0 reset");
        rd(12'h238, 32'h0000_0001, "port15 reset");
        rd(12'h05C, 32'h0000_0000, "unmapped read");
        link(10'h3CF);
        rd(12'h058, 32'h001F_071E, "all events");
        link(10'h020);
        rd(12'h058, 32'h0012_0215, "after accept");
        rd(12'h300, 32'h0000_0001, "irq status");
        check("irq masked", {31'h0, irq_o}, 32'h0000_0000);
        wr(12'h058, 32'h0000_0000, 4'hF);
        rd(12'h058, 32'h0012_0215, "zero write");
        wr(12'h058, 32'hFFFF_FFFF, 4'h0);
        rd(12'h058, 32'h0012_0215, "no lane write");
        wr(12'h058, 32'hFFFF_FFFF, 4'hE);
        rd(12'h058, 32'h0000_0015, "lane 0 kept");
        wr(12'h058, 32'hFFFF_FFFF, 4'hF);
        rd(12'h058, 32'h0000_0001, "one write");
        wr(12'h304, 32'h0000_0001, 4'hF);
        repeat (3) @(posedge sys_clk);
        check("irq unmasked", {31'h0, irq_o}, 32'h0000_0001);
        wr(12'h300, 32'h0000_0001, 4'h1);
        repeat (3) @(posedge sys_clk);
        check("irq cleared", {31'h0, irq_o}, 32'h0000_0000);
        link(10'h200);
        link(10'h210);
        rd(12'h058, 32'h0014_0001, "not accepted");
        check("irq again", {31'h0, irq_o}, 32'h0000_0001);
        give_verdict();
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        give_verdict();
    end
endmodule : tb_top
